// [hw/ctm_pkg.sv]
// package: register map, field layouts and constants of the compact timer
package ctm_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the apb bus
    // ------------------------------------------------------------
    localparam logic [7:0] CTM_TIMER_CONTROL_FIRST_OFS = 8'h00;
    localparam logic [7:0] CTM_TIMER_CONTROL_SECOND_OFS = 8'h04;
    localparam logic [7:0] CTM_COUNTER_LOW_BYTE_OFS = 8'h08;
    localparam logic [7:0] CTM_COUNTER_HIGH_BITS_OFS = 8'h0C;
    localparam logic [7:0] CTM_COMPARE_A_LOW_BYTE_OFS = 8'h10;
    localparam logic [7:0] CTM_COMPARE_A_HIGH_BITS_OFS = 8'h14;
    localparam logic [7:0] CTM_MATCH_FLAGS_OFS = 8'h18;

    // ------------------------------------------------------------
    // widths, field positions and reset values
    // ------------------------------------------------------------
    localparam int CTM_CNT_W = 10;
    localparam int CTM_PER_LSB = 7;
    localparam logic [9:0] CTM_CNT_MAX = 10'h3FF;
    localparam logic [7:0] CTM_CTRL_RESET = 8'h00;
    localparam logic [9:0] CTM_CMP_RESET = 10'h000;
    localparam int CTM_FLAG_A_BIT = 0;
    localparam int CTM_FLAG_P_BIT = 1;
    localparam logic [10:0] CTM_FULL_SPAN = 11'h400;

    // operating modes
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TC = 2'h3;

    // output-function codes
    localparam logic [1:0] CTM_IO_NONE = 2'h0;
    localparam logic [1:0] CTM_IO_LOW = 2'h1;
    localparam logic [1:0] CTM_IO_HIGH = 2'h2;
    localparam logic [1:0] CTM_IO_TOGGLE = 2'h3;

    // first control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic counter_pause;
        logic [2:0] clock_select;
        logic timer_on;
        logic [2:0] period_compare_bits;
    } ctm_ctrl_first_t;

    // second control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] mode_select;
        logic [1:0] output_function;
        logic output_control;
        logic output_invert;
        logic period_duty_swap;
        logic clear_select;
    } ctm_ctrl_second_t;

endpackage

// [hw/ctm_timer.sv]
// compact 10-bit timer with compare output, timer/counter and pwm modes
`timescale 1ns/100ps
// Behaviour
// - polarity bit inverts the output pin; no effect in timer/counter mode
// - swap 0 gives period from 3-bit value, duty from compare-A; 1 reversed
// - clear-select 1 clears on A match; 0 clears on P match or overflow
// - overflow clear under P selection only when period bits are all zero
// - clear-select is ignored in pwm mode
// - counter is read-only, low byte plus two high bits, upper bits zero
// - compare-A is read/write, low byte plus two high bits, resets to zero
// - mode bits 00 compare output, 10 pwm, 11 timer/counter
// - compare mode with clear-select 0 raises both A and P flags
// - clear-select 1 outside pwm raises only the A flag, never the P flag
// - clear-select 1 with compare-A zero overflows at 3FF without A flag
// - in compare mode only A matches change the pin
// - A match drives pin high, low or toggles per function bits; 00 none
// - timer-on rising loads pin with output-control level in compare mode
// - timer/counter mode counts and flags like compare mode, pin undriven
// - pwm uses one compare to clear counter, the other for duty
// - pwm raises A flag on every A match and P flag on every P match
// - pwm output-control picks active level, function bits enable or force
// - swap 0 period is 128 times 3-bit value, 000 gives 1024
// - duty at or above period holds pwm active all period
// - swap 1 period from compare-A, duty from 3-bit value in 128 steps
// - pwm counting and matching continue while the pin is forced
// - each pwm period starts when the period comparator clears the counter
// - period value compared only with counter bits 9 to 7
// - timer-on rise zeroes counter; falling keeps the value and stops
// - pause freezes the counter and resumes from the same value
module ctm_timer
    import ctm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic timer_output_pin_first_out,
    output logic timer_output_pin_second_out,
    output logic pin_enable_out,
    output logic match_a_flag_out,
    output logic match_p_flag_out
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    ctm_ctrl_first_t ctrl0_reg;
    ctm_ctrl_second_t ctrl1_reg;
    logic [9:0] compare_a_value_reg;
    logic [9:0] count_reg;
    logic match_a_flag_reg;
    logic match_p_flag_reg;
    logic cmp_level_reg;
    logic pin_reg;
    logic pin_en_reg;
    logic [31:0] rdata_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic mapped;
    logic sel_c0;
    logic sel_c1;
    logic sel_cl;
    logic sel_ch;
    logic sel_al;
    logic sel_ah;
    logic sel_fl;
    logic [31:0] rd_mux;

    assign setup_ph = psel_in && !penable_in;
    assign access_ph = psel_in && penable_in;
    assign sel_c0 = (paddr_in == CTM_TIMER_CONTROL_FIRST_OFS);
    assign sel_c1 = (paddr_in == CTM_TIMER_CONTROL_SECOND_OFS);
    assign sel_cl = (paddr_in == CTM_COUNTER_LOW_BYTE_OFS);
    assign sel_ch = (paddr_in == CTM_COUNTER_HIGH_BITS_OFS);
    assign sel_al = (paddr_in == CTM_COMPARE_A_LOW_BYTE_OFS);
    assign sel_ah = (paddr_in == CTM_COMPARE_A_HIGH_BITS_OFS);
    assign sel_fl = (paddr_in == CTM_MATCH_FLAGS_OFS);
    assign mapped = sel_c0 | sel_c1 | sel_cl | sel_ch | sel_al | sel_ah | sel_fl;
    // zero wait states; writes land at the access-phase edge
    assign pready_out = access_ph;
    assign pslverr_out = access_ph && !mapped;
    assign wr_en = access_ph && pwrite_in;

    // read mux, registered in the setup phase so prdata comes from a flop
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_c0) begin
            rd_mux[7:0] = ctrl0_reg;
        end else if (sel_c1) begin
            rd_mux[7:0] = ctrl1_reg;
        end else if (sel_cl) begin
            rd_mux[7:0] = count_reg[7:0];
        end else if (sel_ch) begin
            rd_mux[1:0] = count_reg[9:8];
        end else if (sel_al) begin
            rd_mux[7:0] = compare_a_value_reg[7:0];
        end else if (sel_ah) begin
            rd_mux[1:0] = compare_a_value_reg[9:8];
        end else if (sel_fl) begin
            rd_mux[CTM_FLAG_A_BIT] = match_a_flag_reg;
            rd_mux[CTM_FLAG_P_BIT] = match_p_flag_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setup_ph && !pwrite_in) begin
            rdata_reg <= rd_mux;
        end
    end
    assign prdata_out = rdata_reg;

    // ------------------------------------------------------------
    // control and compare registers
    // ------------------------------------------------------------
    logic on_rise;
    assign on_rise = wr_en && sel_c0 && pwdata_in[3] && !ctrl0_reg.timer_on;

    // counter registers have no write path at all
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl0_reg <= CTM_CTRL_RESET;
            ctrl1_reg <= CTM_CTRL_RESET;
            compare_a_value_reg <= CTM_CMP_RESET;
        end else if (wr_en) begin
            if (sel_c0) begin
                ctrl0_reg <= pwdata_in[7:0];
            end else if (sel_c1) begin
                ctrl1_reg <= pwdata_in[7:0];
            end else if (sel_al) begin
                compare_a_value_reg[7:0] <= pwdata_in[7:0];
            end else if (sel_ah) begin
                compare_a_value_reg[9:8] <= pwdata_in[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // comparators and counter
    // ------------------------------------------------------------
    logic [2:0] per_bits;
    logic [1:0] mode;
    logic is_pwm;
    logic is_cmp;
    logic tick;
    logic [10:0] inc;
    logic ovf;
    logic a_raw;
    logic p_raw;
    logic clr;
    logic ev_a;
    logic ev_p;

    assign per_bits = ctrl0_reg.period_compare_bits;
    assign mode = ctrl1_reg.mode_select;
    assign is_pwm = (mode == CTM_MODE_PWM);
    assign is_cmp = (mode == CTM_MODE_CMP);
    // pause and off both stop the count without touching it
    assign tick = ctrl0_reg.timer_on && !ctrl0_reg.counter_pause && !on_rise;
    assign inc = {1'b0, count_reg} + 11'h001;
    assign ovf = inc[10];
    // a match is seen on the value the counter is about to reach
    assign a_raw = (inc[9:0] == compare_a_value_reg) && (compare_a_value_reg != 10'h000);
    // period value meets only the top three bits; zero means the overflow
    assign p_raw = (inc[9:CTM_PER_LSB] == per_bits) && (inc[6:0] == 7'h00)
                   && ((per_bits != 3'h0) || ovf);

    // clear source: pwm picks by swap bit, other modes by clear-select
    always_comb begin
        if (is_pwm) begin
            if (ctrl1_reg.period_duty_swap) begin
                clr = a_raw || ovf;
            end else begin
                clr = p_raw;
            end
        end else if (ctrl1_reg.clear_select) begin
            clr = a_raw || ovf;
        end else begin
            clr = p_raw;
        end
    end

    assign ev_a = tick && a_raw;
    // clear-select 1 suppresses P outside pwm
    assign ev_p = tick && p_raw && (is_pwm || !ctrl1_reg.clear_select);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= 10'h000;
        end else if (on_rise) begin
            count_reg <= 10'h000;
        end else if (tick) begin
            count_reg <= clr ? 10'h000 : inc[9:0];
        end
    end

    // ------------------------------------------------------------
    // match flags, write one to clear; a new match wins the clear
    // ------------------------------------------------------------
    logic clr_flags;
    assign clr_flags = wr_en && sel_fl;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            match_a_flag_reg <= 1'b0;
            match_p_flag_reg <= 1'b0;
        end else begin
            if (ev_a) begin
                match_a_flag_reg <= 1'b1;
            end else if (clr_flags && pwdata_in[CTM_FLAG_A_BIT]) begin
                match_a_flag_reg <= 1'b0;
            end
            if (ev_p) begin
                match_p_flag_reg <= 1'b1;
            end else if (clr_flags && pwdata_in[CTM_FLAG_P_BIT]) begin
                match_p_flag_reg <= 1'b0;
            end
        end
    end
    assign match_a_flag_out = match_a_flag_reg;
    assign match_p_flag_out = match_p_flag_reg;

    // ------------------------------------------------------------
    // compare-mode output level
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmp_level_reg <= 1'b0;
        end else if (on_rise && is_cmp) begin
            cmp_level_reg <= ctrl1_reg.output_control;
        end else if (ev_a && is_cmp) begin
            // only comparator A moves the pin
            case (ctrl1_reg.output_function)
                CTM_IO_LOW: begin
                    cmp_level_reg <= 1'b0;
                end
                CTM_IO_HIGH: begin
                    cmp_level_reg <= 1'b1;
                end
                CTM_IO_TOGGLE: begin
                    cmp_level_reg <= !cmp_level_reg;
                end
                default: begin
                    cmp_level_reg <= cmp_level_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pwm level and pin drive
    // ------------------------------------------------------------
    logic [10:0] duty;
    logic pwm_on;
    logic active_lvl;
    logic pwm_level;
    logic pin_next;
    logic pin_en_next;

    // duty from compare-A, or from the period bits in 128-count steps
    assign duty = ctrl1_reg.period_duty_swap
                  ? ((per_bits == 3'h0) ? CTM_FULL_SPAN : {1'b0, per_bits, 7'h00})
                  : {1'b0, compare_a_value_reg};
    // duty at or past the period keeps the wave active all along
    assign pwm_on = ({1'b0, count_reg} < duty);
    assign active_lvl = ctrl1_reg.output_control;

    // forcing codes only touch the pin; counting runs on regardless
    always_comb begin
        case (ctrl1_reg.output_function)
            CTM_IO_LOW: begin
                pwm_level = active_lvl;
            end
            CTM_IO_HIGH: begin
                pwm_level = pwm_on ? active_lvl : !active_lvl;
            end
            default: begin
                pwm_level = !active_lvl;
            end
        endcase
    end

    // undefined mode code is treated like timer/counter: pin released
    always_comb begin
        pin_en_next = is_cmp || is_pwm;
        if (is_pwm) begin
            pin_next = pwm_level ^ ctrl1_reg.output_invert;
        end else if (is_cmp) begin
            pin_next = cmp_level_reg ^ ctrl1_reg.output_invert;
        end else begin
            pin_next = 1'b0;
        end
    end

    // pin registered, so it trails the internal level by one clock
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_reg <= 1'b0;
            pin_en_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
            pin_en_reg <= pin_en_next;
        end
    end
    assign timer_output_pin_first_out = pin_reg;
    assign timer_output_pin_second_out = pin_reg;
    assign pin_enable_out = pin_en_reg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence run_s;
        tick && !is_pwm;
    endsequence

    sequence stay_s;
        !on_rise && !(wr_en && (sel_c0 || sel_c1));
    endsequence

    pol_invert_a: assert property (is_cmp and stay_s
                                   |=> pin_reg == ($past(cmp_level_reg) ^ $past(ctrl1_reg.output_invert)))
        else $error("compare pin not level xor polarity");
    a_clear_a: assert property (run_s and (ctrl1_reg.clear_select && a_raw) |=> count_reg == 10'h000)
        else $error("counter not cleared on A match");
    ovf_clear_a: assert property (run_s and (!ctrl1_reg.clear_select && per_bits != 3'h0)
                                   |-> !(ovf && !p_raw && clr))
        else $error("overflow clear with nonzero period bits");
    no_p_flag_a: assert property (!is_pwm && ctrl1_reg.clear_select |-> !ev_p)
        else $error("P event with clear-select set");
    a_high_a: assert property (ev_a && is_cmp && !on_rise && ctrl1_reg.output_function == CTM_IO_HIGH
                               |=> cmp_level_reg)
        else $error("A match did not drive high");
    rise_load_a: assert property (on_rise && is_cmp |=> count_reg == 10'h000
                                  && cmp_level_reg == $past(ctrl1_reg.output_control))
        else $error("timer-on rise did not reload");
    tc_release_a: assert property (mode == CTM_MODE_TC ##1 mode == CTM_MODE_TC |-> !pin_enable_out)
        else $error("pin driven in timer/counter mode");
    pause_hold_a: assert property (ctrl0_reg.counter_pause && !on_rise |=> $stable(count_reg))
        else $error("counter moved while paused");
    flag_set_a: assert property (ev_a |=> match_a_flag_reg)
        else $error("A flag not set after A match");
    full_duty_a: assert property (is_pwm && !ctrl1_reg.period_duty_swap
                                  && ctrl1_reg.output_function == CTM_IO_HIGH && per_bits != 3'h0
                                  && compare_a_value_reg >= {per_bits, 7'h00} && count_reg < {per_bits, 7'h00}
                                  and stay_s
                                  |=> pin_reg == (active_lvl ^ ctrl1_reg.output_invert))
        else $error("full duty not held active");
    // a bare overflow clears the count yet never counts as an A match
    ovf_no_a_a: assert property (tick && !is_pwm && ctrl1_reg.clear_select
                                 && compare_a_value_reg == CTM_CMP_RESET && count_reg == CTM_CNT_MAX
                                 |-> !ev_a ##1 count_reg == 10'h000)
        else $error("overflow with compare-A zero misbehaved");
    // with the swap bit set and compare-A nonzero the A comparator closes every period
    swap_period_a: assert property (is_pwm && ctrl1_reg.period_duty_swap && tick && a_raw
                                    |=> count_reg == 10'h000)
        else $error("A match did not end the pwm period");

endmodule // ctm_timer

// [dv/ctm_pin_load.sv]
// load model on the two timer output pins: measures period and high time
`timescale 1ns/100ps
module ctm_pin_load (
    input wire logic clk_in,
    input wire logic pin_first_in,
    input wire logic pin_second_in,
    output int period_cycles,
    output int high_cycles,
    output int rises,
    output logic pins_differ
);
    logic last_lvl = 1'b0;
    int run = 0;
    int hi = 0;

    // a pure load: it only observes, period runs from one rising edge to the next
    always @(posedge clk_in) begin
        if (pin_first_in === 1'b1 && last_lvl === 1'b0) begin
            period_cycles <= run;
            high_cycles <= hi;
            rises <= rises + 1;
            run <= 1;
            hi <= 1;
        end else begin
            run <= run + 1;
            hi <= hi + ((pin_first_in === 1'b1) ? 1 : 0);
        end
        last_lvl <= pin_first_in;
        // both pins carry the same timer output level
        if (pin_first_in !== pin_second_in) begin
            pins_differ <= 1'b1;
        end
    end

    initial begin
        period_cycles = 0;
        high_cycles = 0;
        rises = 0;
        pins_differ = 1'b0;
    end
endmodule // ctm_pin_load

// [dv/tb_top.sv]
// self-checking testbench for the compact timer
`timescale 1ns/100ps
module tb_top;
    import ctm_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic pready_out, pslverr_out, pin_a, pin_b, pin_en, flag_a, flag_p, pins_differ;
    int period_cycles, high_cycles, rises;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    always #25 clk_in = ~clk_in;

    ctm_timer ctm_timer_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .timer_output_pin_first_out(pin_a),
        .timer_output_pin_second_out(pin_b), .pin_enable_out(pin_en), .match_a_flag_out(flag_a),
        .match_p_flag_out(flag_p));

    ctm_pin_load ctm_pin_load_i (.clk_in(clk_in), .pin_first_in(pin_a), .pin_second_in(pin_b),
        .period_cycles(period_cycles), .high_cycles(high_cycles), .rises(rises), .pins_differ(pins_differ));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask

    // one apb transfer; waits for pready rather than assuming zero wait states
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= addr;
        pwdata_in <= wdata;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            $display("unexpected pready: expected 1, seen %0b", pready_out);
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic setup(input logic [7:0] ctrl2, input logic [9:0] cmpa, input logic [2:0] per);
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, 32'h0);
        apb(1'b1, CTM_TIMER_CONTROL_SECOND_OFS, {24'h0, ctrl2});
        apb(1'b1, CTM_COMPARE_A_LOW_BYTE_OFS, {24'h0, cmpa[7:0]});
        apb(1'b1, CTM_COMPARE_A_HIGH_BITS_OFS, {30'h0, cmpa[9:8]});
        apb(1'b1, CTM_MATCH_FLAGS_OFS, 32'h3);
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, {28'h0, 1'b1, per});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs();
        logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            chk("reset value", 32'h0, rd);
        end
        apb(1'b1, CTM_COMPARE_A_LOW_BYTE_OFS, 32'h0000_00A5);
        apb(1'b1, CTM_COMPARE_A_HIGH_BITS_OFS, 32'hFFFF_FFFF);
        apb(1'b0, CTM_COMPARE_A_HIGH_BITS_OFS, 32'h0);
        chk("cmpa high", 32'h3, rd);
        apb(1'b0, CTM_COMPARE_A_LOW_BYTE_OFS, 32'h0);
        chk("cmpa low", 32'hA5, rd);
        apb(1'b1, CTM_COUNTER_LOW_BYTE_OFS, 32'hFF);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("counter read only", 32'h0, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic test_cmp_out();
        logic [3:0] after_lvl = 4'b0101;
        for (int code = 0; code < 4; code++) begin
            setup({CTM_MODE_CMP, code[1:0], 1'b1, 3'b000}, 10'd10, 3'd1);
            repeat (4) @(posedge clk_in);
            chk("initial pin", 32'h1, {31'h0, pin_a});
            repeat (30) @(posedge clk_in);
            chk("pin after A match", {31'h0, after_lvl[code]}, {31'h0, pin_a});
            chk("pin driven", 32'h1, {31'h0, pin_en});
            repeat (300) @(posedge clk_in);
            chk("pin after P match", {31'h0, after_lvl[code]}, {31'h0, pin_a});
            apb(1'b0, CTM_MATCH_FLAGS_OFS, 32'h0);
            chk("both flags", 32'h3, rd);
            apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
            chk("count below period", 32'h1, {31'h0, rd[7:0] < 8'd128});
            apb(1'b0, CTM_COUNTER_HIGH_BITS_OFS, 32'h0);
            chk("count high bits", 32'h0, rd);
        end
        $display("test compare output done");
    endtask

    task automatic test_clear_a();
        setup({CTM_MODE_TC, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1}, 10'd200, 3'd1);
        repeat (500) @(posedge clk_in);
        apb(1'b0, CTM_MATCH_FLAGS_OFS, 32'h0);
        chk("only A flag", 32'h1, rd);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("count below cmpa", 32'h1, {31'h0, rd[7:0] < 8'd200});
        chk("pin released", 32'h0, {31'h0, pin_en});
        setup({CTM_MODE_TC, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1}, 10'd0, 3'd1);
        repeat (1100) @(posedge clk_in);
        apb(1'b0, CTM_MATCH_FLAGS_OFS, 32'h0);
        chk("no flag at overflow", 32'h0, rd);
        $display("test clear on A done");
    endtask

    task automatic pwm_meas(input logic [7:0] c2, input logic [9:0] a, input logic [2:0] p, input int ep,
                            input int eh, input int w);
        setup(c2, a, p);
        repeat (w) @(posedge clk_in);
        chk("pwm period", ep, period_cycles);
        chk("pwm high time", eh, high_cycles);
    endtask

    task automatic test_pwm();
        int r0;
        pwm_meas({CTM_MODE_PWM, CTM_IO_TOGGLE - 2'h1, 4'b1000}, 10'd32, 3'd1, 128, 32, 400);
        pwm_meas({CTM_MODE_PWM, 2'h2, 4'b1100}, 10'd32, 3'd1, 128, 96, 400);
        pwm_meas({CTM_MODE_PWM, 2'h2, 4'b0000}, 10'd32, 3'd1, 128, 96, 400);
        pwm_meas({CTM_MODE_PWM, 2'h2, 4'b1011}, 10'd300, 3'd1, 300, 128, 1000);
        pwm_meas({CTM_MODE_PWM, 2'h2, 4'b1001}, 10'd100, 3'd3, 384, 100, 1200);
        apb(1'b0, CTM_MATCH_FLAGS_OFS, 32'h0);
        chk("pwm flags", 32'h3, rd);
        setup({CTM_MODE_PWM, 2'h2, 4'b1000}, 10'd200, 3'd1);
        repeat (20) @(posedge clk_in);
        r0 = rises;
        repeat (300) @(posedge clk_in);
        chk("full duty edges", r0, rises);
        chk("full duty level", 32'h1, {31'h0, pin_a});
        setup({CTM_MODE_PWM, 2'h1, 4'b1000}, 10'd32, 3'd1);
        repeat (300) @(posedge clk_in);
        chk("forced active", 32'h1, {31'h0, pin_a});
        apb(1'b0, CTM_MATCH_FLAGS_OFS, 32'h0);
        chk("matching while forced", 32'h3, rd);
        setup({CTM_MODE_PWM, 2'h0, 4'b1000}, 10'd32, 3'd1);
        repeat (10) @(posedge clk_in);
        chk("forced inactive", 32'h0, {31'h0, pin_a});
        chk("pins agree", 32'h0, {31'h0, pins_differ});
        $display("test pwm done");
    endtask

    task automatic test_pause();
        logic [7:0] a;
        setup({CTM_MODE_TC, 6'h0}, 10'd0, 3'd0);
        repeat (100) @(posedge clk_in);
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, 32'h88);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        a = rd[7:0];
        repeat (50) @(posedge clk_in);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("paused count", {24'h0, a}, rd);
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, 32'h08);
        repeat (20) @(posedge clk_in);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("resumed count", 32'h1, {31'h0, rd[7:0] > a});
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, 32'h00);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        a = rd[7:0];
        repeat (30) @(posedge clk_in);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("stopped count", {24'h0, a}, rd);
        apb(1'b1, CTM_TIMER_CONTROL_FIRST_OFS, 32'h08);
        apb(1'b0, CTM_COUNTER_LOW_BYTE_OFS, 32'h0);
        chk("count restarted", 32'h1, {31'h0, rd[7:0] < 8'd10});
        $display("test pause done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        test_regs();
        test_cmp_out();
        test_clear_a();
        test_pwm();
        test_pause();
        tally_and_finish();
    end
endmodule // tb_top
